//--- rtl/uart_addr_cfg.svh
// Constants of the serial control and address recognition block.
// Assumes a 32-bit AXI4-Lite slave on a 12-bit byte address.
//
// Summary of operation
// - Recognition runs only while multiproc_enable is set.
// - Receive flag only for frames addressed here.
// - 8-bit mode: stop bit acts as ninth bit.
// - Shift register mode ignores multiproc_enable entirely.
// - Individual or broadcast address match both recognise.
// - Individual match compares only mask one bits.
// - Broadcast address is own OR mask.
// - Control bit 7 is error flag or mode.
// - Error flag set on bad stop, software clears.
// - Mode bits select shift, 8-bit or 9-bit UART.
// - Multiprocessor filtering applies in 9-bit modes.
// - Reception enable gates all received frames.
// - 9-bit modes send tx_ninth_bit as ninth bit.
// - 9-bit modes load rx_ninth_bit from frame.
// - Transmit flag set at data or stop edge.
// - Shift mode sets receive flag after eighth bit.
// - Error detection moves receive flag to stop bit.
// - baud_doubler doubles rate in UART modes only.
// - Own address register resets to zero.
`ifndef UART_ADDR_CFG_SVH
`define UART_ADDR_CFG_SVH

// ---------------------------------------------------------------
// Register indices; byte address is four times the index.
// ---------------------------------------------------------------
`define IDX_SERIAL_CONTROL 8'h98
`define IDX_RX_BUFFER 8'h99
`define IDX_OWN_ADDRESS 8'hA9
`define IDX_ADDRESS_MASK 8'hB9
`define IDX_POWER_CONTROL 8'h87

// ---------------------------------------------------------------
// Field positions and reset values.
// ---------------------------------------------------------------
`define SC_BIT_MODE_HI 7
`define SC_BIT_MODE_LO 6
`define SC_BIT_MULTIPROC 5
`define SC_BIT_RX_ENABLE 4
`define SC_BIT_TX_NINTH 3
`define SC_BIT_RX_NINTH 2
`define SC_BIT_TX_DONE 1
`define SC_BIT_RX_DONE 0
`define PC_BIT_DOUBLER 7
`define PC_BIT_ERR_SELECT 6
`define RST_BYTE 8'h00

// ---------------------------------------------------------------
// Modes, fixed divisors and bus answers.
// ---------------------------------------------------------------
`define MODE_SHIFT 2'h0
`define MODE_UART8 2'h1
`define MODE_UART9_FIXED 2'h2
`define MODE_UART9_VAR 2'h3
`define DIV_SHIFT_STD 7'h0C
`define DIV_SHIFT_HALF 7'h06
`define DIV_FIXED_STD 7'h40
`define DIV_FIXED_DBL 7'h20
`define DIV_VARIABLE 7'h00
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/uart_addr_pkg.sv
// Types shared by the serial control block, its monitor, node model and bench.
// Assumes the constants header is included by the users of the package.
package uart_addr_pkg;

  // Events from the receive shifter, one-cycle pulses on SYS_CLK.
  typedef struct packed {
    logic last_data;
    logic [7:0] data;
    logic ninth;
    logic stop;
    logic stop_ok;
  } rx_evt_s;

  // Events from the transmit shifter, one-cycle pulses on SYS_CLK.
  typedef struct packed {
    logic bit8_end;
    logic stop_start;
  } tx_evt_s;

  // Register selected by a bus address.
  typedef enum logic [2:0] {
    SEL_NONE, SEL_SERIAL_CONTROL, SEL_POWER_CONTROL_REG, SEL_OWN, SEL_MASK, SEL_RXBUF
  } reg_sel_e;

  // Whole state of the top module.
  typedef struct packed {
    logic mode_hi;
    logic mode_lo;
    logic multiproc;
    logic rx_en;
    logic tx_ninth;
    logic rx_ninth;
    logic tx_done;
    logic rx_done;
    logic stop_err;
    logic doubler;
    logic err_sel;
    logic [7:0] own;
    logic [7:0] mask;
    logic [7:0] rx_buf;
    logic [7:0] pend_byte;
    logic rx_accept;
    logic recog;
    logic tx_ninth_out;
    logic baud_double;
    logic [6:0] baud_div;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [11:0] awaddr;
    logic [7:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } st_s;

endpackage

//--- rtl/uart_addr_match.sv
// Address comparator for received address frames.
// Assumes address, own address and mask are stable in the cycle of use.
`timescale 1ns/1ps
`default_nettype none

module uart_addr_match #(
  parameter int WIDTH = 8
) (
  // Frame address and the two address registers.
  input wire logic [WIDTH-1:0] addr,
  input wire logic [WIDTH-1:0] own,
  input wire logic [WIDTH-1:0] mask,
  // Match result.
  output logic hit
);

  logic [WIDTH-1:0] given_ok;
  logic [WIDTH-1:0] bcast_ok;

  // Each bit either is a don't-care or agrees with the wanted value.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign given_ok[i] = ~mask[i] | (addr[i] == own[i]);
    assign bcast_ok[i] = ~(own[i] | mask[i]) | addr[i];
  end

  // Either address recognises the frame.
  assign hit = (&given_ok) | (&bcast_ok);

endmodule // uart_addr_match
`default_nettype wire

//--- rtl/uart_addr_recog.sv
// Serial control, power control bits and address recognition.
// Assumes shifter events arrive on SYS_CLK and an AXI4-Lite master.
// Assumes HALF_CLOCK_MODE is a level from logic on the same clock.
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "uart_addr_cfg.svh"

module uart_addr_recog (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  // AXI4-Lite write address.
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [11:0] AWADDR,
  // AXI4-Lite write data.
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  // AXI4-Lite write response.
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // AXI4-Lite read address.
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [11:0] ARADDR,
  // AXI4-Lite read data.
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  // Shifter events and clock option.
  input wire uart_addr_pkg::rx_evt_s RX_EVT,
  input wire uart_addr_pkg::tx_evt_s TX_EVT,
  input wire logic HALF_CLOCK_MODE,
  // Configuration towards the shifters and baud logic.
  output logic [1:0] MODE,
  output logic RX_ENABLE,
  output logic RECOG_ACTIVE,
  output logic TX_NINTH_BIT,
  output logic BAUD_DOUBLE,
  output logic [6:0] BAUD_DIVISOR,
  // Status towards the core.
  output logic RX_DONE_FLAG,
  output logic TX_DONE_FLAG,
  output logic FRAME_STOP_ERROR,
  output logic [7:0] RX_BYTE,
  output logic RX_ACCEPT
);
  import uart_addr_pkg::*;

  // ---------------------------------------------------------------
  // State and reset value.
  // ---------------------------------------------------------------
  // The ready signals rest high, so the first request after reset is taken
  // at its first edge; everything else, both address registers included,
  // comes up as zero.
  localparam st_s RST_VAL = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

  // One packed state word; the combinational copy is its next value.
  st_s s_q;
  st_s s_d;
  logic [7:0] match_addr;
  logic addr_hit;

  // Decodes a byte address into a register; used for reads and writes.
  function automatic reg_sel_e decode(input logic [11:0] a);
    reg_sel_e r;
    r = SEL_NONE;
    // Only the low index window answers; aliases above it read as unmapped
    // so that a stray pointer gets an error rather than a silent hit.
    if (a[11:10] == 2'h0) begin
      case (a[9:2])
        `IDX_SERIAL_CONTROL: r = SEL_SERIAL_CONTROL;
        `IDX_POWER_CONTROL: r = SEL_POWER_CONTROL_REG;
        `IDX_OWN_ADDRESS: r = SEL_OWN;
        `IDX_ADDRESS_MASK: r = SEL_MASK;
        `IDX_RX_BUFFER: r = SEL_RXBUF;
        default: r = SEL_NONE;
      endcase
    end
    return r;
  endfunction

  // Builds the read image of a register.
  function automatic logic [7:0] read_image(input reg_sel_e r, input st_s s);
    logic [7:0] v;
    v = `RST_BYTE;
    case (r)
      SEL_SERIAL_CONTROL: begin
        v[`SC_BIT_MODE_HI] = s.err_sel ? s.stop_err : s.mode_hi;
        v[`SC_BIT_MODE_LO] = s.mode_lo;
        v[`SC_BIT_MULTIPROC] = s.multiproc;
        v[`SC_BIT_RX_ENABLE] = s.rx_en;
        v[`SC_BIT_TX_NINTH] = s.tx_ninth;
        v[`SC_BIT_RX_NINTH] = s.rx_ninth;
        v[`SC_BIT_TX_DONE] = s.tx_done;
        v[`SC_BIT_RX_DONE] = s.rx_done;
      end
      // The other power control bits do not exist here and read as zero.
      SEL_POWER_CONTROL_REG: begin
        v[`PC_BIT_DOUBLER] = s.doubler;
        v[`PC_BIT_ERR_SELECT] = s.err_sel;
      end
      SEL_OWN: v = s.own;
      SEL_MASK: v = s.mask;
      SEL_RXBUF: v = s.rx_buf;
      default: v = `RST_BYTE;
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Address comparison.
  // ---------------------------------------------------------------
  // At the last data bit the byte comes straight from the shifter; at the
  // stop bit the copy held since then is compared instead.
  assign match_addr = RX_EVT.last_data ? RX_EVT.data : s_q.pend_byte;

  // The matcher is purely combinational; its result is used only in the
  // cycle of a last-data or stop event, so a register change in between
  // affects only frames that end after it.
  uart_addr_match #(
    .WIDTH(8)
  ) u_match (
    .addr(match_addr),
    .own(s_q.own),
    .mask(s_q.mask),
    .hit(addr_hit)
  );

  // ---------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------
  // Software writes are applied first and hardware events afterwards, so
  // an event landing in the same cycle as a clearing write is kept.
  always_comb begin
    logic [1:0] mode;
    logic nine;
    logic deliver;
    logic accept;
    logic [7:0] wbyte;
    reg_sel_e wsel;
    // Locals get a value first so that no path leaves a latch.
    mode = 2'h0;
    nine = 1'b0;
    deliver = 1'b0;
    accept = 1'b0;
    wbyte = `RST_BYTE;
    wsel = SEL_NONE;
    s_d = s_q;
    s_d.rx_accept = 1'b0;

    // Write channel: address and data are taken in either order.
    if (AWVALID && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = AWADDR;
      s_d.awready = 1'b0;
    end
    if (WVALID && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = WDATA[7:0];
      s_d.wstrb0 = WSTRB[0];
      s_d.wready = 1'b0;
    end

    // Write response retires and the channels reopen.
    if (s_q.bvalid && BREADY) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // Register write once both halves are present.
    if (s_d.aw_have && s_d.w_have && !s_q.bvalid) begin
      wsel = decode(s_d.awaddr);
      wbyte = s_d.wdata;
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      // A cleared byte strobe still answers OKAY but changes nothing.
      if (s_d.wstrb0) begin
        case (wsel)
          SEL_SERIAL_CONTROL: begin
            // Bit 7 lands in whichever function the error select shows.
            if (s_q.err_sel) begin
              s_d.stop_err = wbyte[`SC_BIT_MODE_HI];
            end else begin
              s_d.mode_hi = wbyte[`SC_BIT_MODE_HI];
            end
            s_d.mode_lo = wbyte[`SC_BIT_MODE_LO];
            s_d.multiproc = wbyte[`SC_BIT_MULTIPROC];
            s_d.rx_en = wbyte[`SC_BIT_RX_ENABLE];
            s_d.tx_ninth = wbyte[`SC_BIT_TX_NINTH];
            s_d.rx_ninth = wbyte[`SC_BIT_RX_NINTH];
            s_d.tx_done = wbyte[`SC_BIT_TX_DONE];
            s_d.rx_done = wbyte[`SC_BIT_RX_DONE];
          end
          SEL_POWER_CONTROL_REG: begin
            s_d.doubler = wbyte[`PC_BIT_DOUBLER];
            s_d.err_sel = wbyte[`PC_BIT_ERR_SELECT];
          end
          SEL_OWN: s_d.own = wbyte;
          SEL_MASK: s_d.mask = wbyte;
          default: s_d.own = s_d.own;
        endcase
      end
    end

    // Read channel: one cycle from address to data.
    // The image is taken from the state before this edge, so a write that
    // lands in the same cycle shows up only on the next read.
    if (s_q.rvalid && RREADY) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (ARVALID && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rdata = {24'h00_0000, read_image(decode(ARADDR), s_q)};
      s_d.rresp = (decode(ARADDR) == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end

    // Mode as seen by the receiver in this cycle.
    mode = {s_q.mode_hi, s_q.mode_lo};
    nine = mode[1];

    // Recognition never runs in shift register mode.
    // It follows the next-state bits so that it changes on the write edge.
    s_d.recog = s_d.multiproc && ({s_d.mode_hi, s_d.mode_lo} != `MODE_SHIFT);

    // End of the last data bit.
    // Trade-off: with error detection on in the UART modes, nothing is delivered here and the
    // stop bit decides, which delays the flag by one bit time.
    if (RX_EVT.last_data && s_q.rx_en) begin
      s_d.pend_byte = RX_EVT.data;
      if (mode == `MODE_SHIFT) begin
        deliver = 1'b1;
        accept = 1'b1;
      end else if (nine) begin
        s_d.rx_ninth = RX_EVT.ninth;
        if (!s_q.err_sel) begin
          deliver = 1'b1;
          // Data frames and foreign addresses are dropped here.
          accept = !s_q.recog || (RX_EVT.ninth && addr_hit);
        end
      end else if (!s_q.err_sel && !s_q.recog) begin
        deliver = 1'b1;
        accept = 1'b1;
      end
    end

    // Stop bit sample of the asynchronous modes.
    if (RX_EVT.stop && s_q.rx_en && (mode != `MODE_SHIFT)) begin
      if (s_q.err_sel && !RX_EVT.stop_ok) begin
        s_d.stop_err = 1'b1;
      end
      if (!nine) begin
        // The stop bit stands in for the missing ninth bit.
        s_d.rx_ninth = RX_EVT.stop_ok;
        if (s_q.err_sel || s_q.recog) begin
          deliver = 1'b1;
          accept = !s_q.recog || (RX_EVT.stop_ok && addr_hit);
        end
      end else if (s_q.err_sel) begin
        deliver = 1'b1;
        accept = !s_q.recog || (s_q.rx_ninth && addr_hit);
      end
    end

    // Hand the frame to the core.
    // Limitation: a new frame overwrites the buffer even if the flag is
    // still set; software that falls behind loses the older byte.
    if (deliver && accept) begin
      s_d.rx_done = 1'b1;
      s_d.rx_buf = s_q.pend_byte;
      if (RX_EVT.last_data) begin
        s_d.rx_buf = RX_EVT.data;
      end
      s_d.rx_accept = 1'b1;
    end

    // Transmit flag at the end of the data or the start of stop.
    // The set wins over a clearing write in the same cycle, as for receive.
    if ((mode == `MODE_SHIFT) ? TX_EVT.bit8_end : TX_EVT.stop_start) begin
      s_d.tx_done = 1'b1;
    end

    // Configuration outputs, registered so they follow the write.
    s_d.tx_ninth_out = s_d.mode_hi & s_d.tx_ninth;
    s_d.baud_double = s_d.doubler && ({s_d.mode_hi, s_d.mode_lo} != `MODE_SHIFT);
    case ({s_d.mode_hi, s_d.mode_lo})
      `MODE_SHIFT: s_d.baud_div = HALF_CLOCK_MODE ? `DIV_SHIFT_HALF : `DIV_SHIFT_STD;
      `MODE_UART9_FIXED: s_d.baud_div = s_d.doubler ? `DIV_FIXED_DBL : `DIV_FIXED_STD;
      default: s_d.baud_div = `DIV_VARIABLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------
  // Reset clears the address registers along with all control bits.
  // No clock enable: the whole state word moves on every edge.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s_q <= RST_VAL;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, each a field of the state register.
  // ---------------------------------------------------------------
  // Nothing below is combinational, so the ports carry no glitches.
  // Bus handshake signals.
  assign AWREADY = s_q.awready;
  assign WREADY = s_q.wready;
  assign BVALID = s_q.bvalid;
  assign BRESP = s_q.bresp;
  assign ARREADY = s_q.arready;
  assign RVALID = s_q.rvalid;
  assign RDATA = s_q.rdata;
  assign RRESP = s_q.rresp;

  // Configuration and status; the hidden mode bit keeps steering the
  // shifters even while bit 7 reads back as the error flag.
  assign MODE = {s_q.mode_hi, s_q.mode_lo};
  assign RX_ENABLE = s_q.rx_en;
  assign RECOG_ACTIVE = s_q.recog;
  assign TX_NINTH_BIT = s_q.tx_ninth_out;
  assign BAUD_DOUBLE = s_q.baud_double;
  assign BAUD_DIVISOR = s_q.baud_div;
  assign RX_DONE_FLAG = s_q.rx_done;
  assign TX_DONE_FLAG = s_q.tx_done;
  assign FRAME_STOP_ERROR = s_q.stop_err;
  assign RX_BYTE = s_q.rx_buf;
  assign RX_ACCEPT = s_q.rx_accept;

endmodule // uart_addr_recog
`default_nettype wire

//--- verif/uart_addr_recog_monitor.sv
// Concurrent checks on the ports of the serial control block.
// Assumes one clock domain and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module uart_addr_recog_monitor (
  // Clock, reset and watched ports.
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire uart_addr_pkg::rx_evt_s RX_EVT,
  input wire uart_addr_pkg::tx_evt_s TX_EVT,
  input wire logic [1:0] MODE,
  input wire logic RX_ENABLE,
  input wire logic RECOG_ACTIVE,
  input wire logic TX_NINTH_BIT,
  input wire logic BAUD_DOUBLE,
  input wire logic [6:0] BAUD_DIVISOR,
  input wire logic RX_DONE_FLAG,
  input wire logic TX_DONE_FLAG,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_ACCEPT
);
  import uart_addr_pkg::*;
  // Every check samples on the one clock and sleeps during reset.
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  chk_accept_sets_flag: assert property (RX_ACCEPT |-> RX_DONE_FLAG)
    else $error("accepted frame left receive flag low");
  chk_accept_one_cycle: assert property (RX_ACCEPT |=> !RX_ACCEPT)
    else $error("accept pulse longer than one cycle");
  chk_shift_no_extras: assert property (MODE == 2'h0 |-> !RECOG_ACTIVE && !BAUD_DOUBLE)
    else $error("recognition or doubling active in shift mode");
  chk_fixed_divisor: assert property (MODE == 2'h2 && $stable(MODE) && $stable(BAUD_DOUBLE)
    |-> BAUD_DIVISOR == (BAUD_DOUBLE ? 7'h20 : 7'h40))
    else $error("fixed rate divisor wrong");
  chk_ninth_tx_modes: assert property (TX_NINTH_BIT |-> MODE[1])
    else $error("ninth transmit bit outside nine-bit modes");
  chk_rx_gated: assert property (RX_EVT.last_data && !RX_ENABLE |=> !RX_ACCEPT)
    else $error("frame accepted while reception disabled");
  chk_shift_receive: assert property (RX_EVT.last_data && RX_ENABLE && MODE == 2'h0
    |=> RX_ACCEPT && RX_DONE_FLAG && RX_BYTE == $past(RX_EVT.data))
    else $error("shift mode byte not received");
  chk_tx_flag_set: assert property (TX_EVT.stop_start && MODE != 2'h0 |=> TX_DONE_FLAG)
    else $error("transmit flag not set at stop start");
endmodule // uart_addr_recog_monitor

bind uart_addr_recog uart_addr_recog_monitor u_mon (.SYS_CLK, .RESET_N, .RX_EVT, .TX_EVT,
  .MODE, .RX_ENABLE, .RECOG_ACTIVE, .TX_NINTH_BIT, .BAUD_DOUBLE, .BAUD_DIVISOR,
  .RX_DONE_FLAG, .TX_DONE_FLAG, .RX_BYTE, .RX_ACCEPT);

`default_nettype wire

//--- verif/uart_node_model.sv
// Far serial node: delivers each frame as receive shifter events.
// Assumes the block samples events on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module uart_node_model (
  // Clock and event output.
  input wire logic clk,
  output var uart_addr_pkg::rx_evt_s evt
);
  import uart_addr_pkg::*;
  // Quiet at start.
  initial evt = '0;
  // Between the two pulses the byte fields carry inverted data, and after the stop pulse stop_ok is inverted, so stale values never pass.
  task automatic frame(input logic [7:0] d, input logic n, input logic ok);
    @(posedge clk);
    evt <= '{1'b1, d, n, 1'b0, 1'b0};
    @(posedge clk);
    evt <= '{1'b0, ~d, ~n, 1'b0, 1'b0};
    repeat (3) @(posedge clk);
    evt <= '{1'b0, ~d, ~n, 1'b1, ok};
    @(posedge clk);
    evt <= '{1'b0, d, n, 1'b0, ~ok};
    repeat (3) @(posedge clk);
  endtask
endmodule // uart_node_model

`default_nettype wire

//--- verif/uart_addr_recog_tb_top.sv
// Self-checking bench for serial control and address recognition.
// Assumes the node model feeds receive events; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none

module uart_addr_recog_tb_top;
  import uart_addr_pkg::*;
  localparam logic [11:0] A_SC = 12'h260, A_OWN = 12'h2A4, A_MASK = 12'h2E4, A_PC = 12'h21C;
  logic SYS_CLK = 1'b0, RESET_N = 1'b0, HALF_CLOCK_MODE = 1'b0;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic [11:0] AWADDR = 12'h000, ARADDR = 12'h000;
  logic [31:0] WDATA = 32'h0000_0000, RDATA;
  logic [3:0] WSTRB = 4'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, RX_ENABLE, RECOG_ACTIVE, TX_NINTH_BIT;
  logic BAUD_DOUBLE, RX_DONE_FLAG, TX_DONE_FLAG, FRAME_STOP_ERROR, RX_ACCEPT;
  logic [1:0] BRESP, RRESP, MODE;
  logic [6:0] BAUD_DIVISOR;
  logic [7:0] RX_BYTE;
  rx_evt_s RX_EVT;
  tx_evt_s TX_EVT = '0;
  int errors = 0, compares = 0;

  uart_addr_recog u_dut (
    .SYS_CLK, .RESET_N, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA,
    .RRESP, .RX_EVT, .TX_EVT, .HALF_CLOCK_MODE, .MODE, .RX_ENABLE, .RECOG_ACTIVE,
    .TX_NINTH_BIT, .BAUD_DOUBLE, .BAUD_DIVISOR, .RX_DONE_FLAG, .TX_DONE_FLAG,
    .FRAME_STOP_ERROR, .RX_BYTE, .RX_ACCEPT);
  uart_node_model u_node (.clk(SYS_CLK), .evt(RX_EVT));

  // Free-running 10 MHz clock.
  always #50 SYS_CLK = ~SYS_CLK;

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  // Compare one value and count it.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Address and data go out together; each is held until its own ready.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge SYS_CLK);
    AWADDR <= a;
    WDATA <= {24'h00_0000, d};
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!done) begin
      @(posedge SYS_CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID) begin
        chk("write resp", BRESP, 2'h0);
        BREADY <= 1'b0;
        done = 1'b1;
      end
    end
    // Let the configuration outputs settle before anyone looks.
    repeat (2) @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge SYS_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!done) begin
      @(posedge SYS_CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID) begin
        d = RDATA;
        r = RRESP;
        RREADY <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(nm, d, exp);
    chk({nm, " resp"}, r, 2'h0);
  endtask
  // One transmit event pulse, then time for the flag to show.
  task automatic tx_pulse(input logic b8, input logic st);
    @(posedge SYS_CLK);
    TX_EVT <= '{b8, st};
    @(posedge SYS_CLK);
    TX_EVT <= '0;
    repeat (2) @(posedge SYS_CLK);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    rdchk("control reset", A_SC, 8'h00);
    rdchk("own reset", A_OWN, 8'h00);
    rdchk("mask reset", A_MASK, 8'h00);
    rd(12'h100, d, r);
    chk("unmapped resp", r, 2'h2);
  endtask
  task automatic t_modes();
    logic [6:0] dv [4] = '{7'h0C, 7'h00, 7'h40, 7'h00};
    for (int m = 0; m < 4; m++) begin
      wr(A_SC, {m[1:0], 6'h10});
      chk("mode", MODE, m[1:0]);
      chk("divisor", BAUD_DIVISOR, dv[m]);
      chk("rx enable", RX_ENABLE, 1'b1);
    end
  endtask
  // Multiprocessor bit set in shift mode must change nothing.
  task automatic t_shift();
    HALF_CLOCK_MODE <= 1'b1;
    wr(A_SC, 8'h30);
    chk("shift recog", RECOG_ACTIVE, 1'b0);
    chk("half divisor", BAUD_DIVISOR, 7'h06);
    u_node.frame(8'hA3, 1'b0, 1'b1);
    chk("shift flag", RX_DONE_FLAG, 1'b1);
    chk("shift byte", RX_BYTE, 8'hA3);
    tx_pulse(1'b0, 1'b1);
    chk("shift stop tx", TX_DONE_FLAG, 1'b0);
    tx_pulse(1'b1, 1'b0);
    chk("shift tx flag", TX_DONE_FLAG, 1'b1);
    HALF_CLOCK_MODE <= 1'b0;
  endtask
  // Own 0x56 under mask 0xFC: given 0101_01xx, broadcast 1111_111x.
  task automatic t_recog9();
    logic [9:0] tbl [4] = '{{8'h57, 2'b11}, {8'h5A, 2'b10}, {8'hFF, 2'b11}, {8'h56, 2'b00}};
    wr(A_OWN, 8'h56);
    wr(A_MASK, 8'hFC);
    foreach (tbl[i]) begin
      wr(A_SC, 8'hF0);
      u_node.frame(tbl[i][9:2], tbl[i][1], 1'b1);
      chk("recog flag", RX_DONE_FLAG, tbl[i][0]);
      rdchk("rx ninth", A_SC, {4'hF, 1'b0, tbl[i][1], 1'b0, tbl[i][0]});
    end
    chk("recog on", RECOG_ACTIVE, 1'b1);
    wr(A_SC, 8'hD0);
    chk("recog off", RECOG_ACTIVE, 1'b0);
    u_node.frame(8'h5A, 1'b0, 1'b1);
    chk("open flag", RX_DONE_FLAG, 1'b1);
  endtask
  // Eight-bit mode: the stop bit stands in for the ninth bit.
  task automatic t_uart8();
    wr(A_SC, 8'h70);
    u_node.frame(8'h57, 1'b1, 1'b0);
    chk("bad stop flag", RX_DONE_FLAG, 1'b0);
    u_node.frame(8'h57, 1'b0, 1'b1);
    chk("good stop flag", RX_DONE_FLAG, 1'b1);
    tx_pulse(1'b1, 1'b0);
    chk("tx early", TX_DONE_FLAG, 1'b0);
    tx_pulse(1'b0, 1'b1);
    chk("tx flag", TX_DONE_FLAG, 1'b1);
  endtask
  // A good stop after a bad one must not clear the error.
  task automatic t_ferr();
    wr(A_PC, 8'h40);
    wr(A_SC, 8'h50);
    u_node.frame(8'h11, 1'b0, 1'b0);
    chk("frame error", FRAME_STOP_ERROR, 1'b1);
    rdchk("error in bit7", A_SC, 8'hD1);
    u_node.frame(8'h11, 1'b0, 1'b1);
    chk("error kept", FRAME_STOP_ERROR, 1'b1);
    wr(A_SC, 8'h50);
    chk("error cleared", FRAME_STOP_ERROR, 1'b0);
    wr(A_PC, 8'h00);
  endtask
  task automatic t_misc();
    wr(A_SC, 8'h00);
    u_node.frame(8'h3C, 1'b0, 1'b1);
    chk("disabled flag", RX_DONE_FLAG, 1'b0);
    wr(A_SC, 8'h88);
    chk("tx ninth", TX_NINTH_BIT, 1'b1);
    wr(A_PC, 8'h80);
    chk("doubled", BAUD_DOUBLE, 1'b1);
    chk("doubled divisor", BAUD_DIVISOR, 7'h20);
    wr(A_SC, 8'h00);
    chk("shift undoubled", BAUD_DOUBLE, 1'b0);
    chk("shift divisor", BAUD_DIVISOR, 7'h0C);
  endtask

  // Print the counts and the verdict, then stop.
  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after ten cycles of reset.
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    t_reset();
    t_modes();
    t_shift();
    t_recog9();
    t_uart8();
    t_ferr();
    t_misc();
    results();
  end
  // Watchdog: the run needs about 260 cycles, so 20000 means a hang.
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    errors++;
    results();
  end
endmodule // uart_addr_recog_tb_top

`default_nettype wire
